// [design/sync_count_regs.svh]
// Offsets, field positions, reset values and counts of the sync count block.
// Assumes byte addresses on a 16-bit register port; included by bare name.
`ifndef SYNC_COUNT_REGS_SVH
`define SYNC_COUNT_REGS_SVH
// ==========================================================
// Register offsets
`define OFS_FIFO_DEPTH      10'h018
`define OFS_IRQ_STATUS      10'h020
`define OFS_IRQ_MASK        10'h022
`define OFS_FILTER_CTRL     10'h024
`define OFS_REJECT_FILTER   10'h026
`define OFS_ACCEPT_VALUE    10'h028
`define OFS_ACCEPT_MASK     10'h02A
`define OFS_NODE_CONFIG     10'h02C
`define OFS_TX_IDENT        10'h180
`define OFS_TX_CYCLE_LEN    10'h182
`define OFS_TX_HDR_CHECK    10'h184
`define OFS_TX_PAYLOAD0     10'h186
`define OFS_TX_PAYLOAD15    10'h1A4
`define OFS_BUFFER0         10'h200
`define OFS_BUFFER58        10'h2E8
`define OFS_EVEN_COUNT      10'h33C
`define OFS_ODD_COUNT       10'h33E
// ==========================================================
// Field positions and masks
`define BUF_IRQ_FLAG_BIT    2
`define BUF_WRITE_MASK      16'hFF4D
`define NODE_SENDS_SYNC_BIT 15
`define IRQ_EVEN_COUNTED    0
`define IRQ_ODD_COUNTED     1
`define IRQ_FIFO_REFUSED    2
// ==========================================================
// Reset values and counts
`define RST_FIFO_DEPTH      6'h00
`define RST_BUFFER_WORD     16'h0000
`define BUFFER_COUNT        59
`define BUFFER_LAST         6'h3A
`define FIFO_CODE_MAX       6'h3A
`define FIFO_ALL_BUFFERS    6'h3B
`define COUNT_FULL          4'hF
`endif

// [design/sync_count_pkg.sv]
// Types shared by the sync count block and whoever connects to it.
// Assumes one protocol clock; the engine inputs come from the same clock.
package sync_count_pkg;
    // ==========================================================
    // Protocol state reported by the engine, one-hot.
    typedef enum logic [5:0] {
        POC_CONFIG              = 6'h01,
        POC_INIT_SCHEDULE       = 6'h02,
        POC_COLDSTART_COLLISION = 6'h04,
        POC_NORMAL_ACTIVE       = 6'h08,
        POC_NORMAL_PASSIVE      = 6'h10,
        POC_OTHER               = 6'h20
    } poc_state_t;
    // Host register request.
    typedef struct packed {
        logic [9:0]  addr;
        logic [15:0] wdata;
        logic        write;
        logic        read;
    } reg_req_t;
    // Events and state from the protocol engine.
    typedef struct packed {
        poc_state_t  state;
        logic        cycle_odd;
        logic        idle_odd;
        logic        even_end;
        logic        sync_valid;
        logic [10:0] sync_id;
        logic        buf_event;
        logic [5:0]  buf_event_idx;
    } engine_in_t;
    // Writes into the sync identifier tables.
    typedef struct packed {
        logic        even_we;
        logic [3:0]  even_idx;
        logic [10:0] even_id;
        logic        odd_we;
        logic [3:0]  odd_idx;
        logic [10:0] odd_id;
    } ident_write_t;
    // Whole state of the block.
    typedef struct packed {
        logic [3:0]        even_count;
        logic [3:0]        odd_count;
        logic [5:0]        fifo_code;
        logic [58:0][15:0] bufw;
        logic [15:0]       tx_ident;
        logic [6:0]        tx_len;
        logic [10:0]       tx_hcrc;
        logic [15:0][15:0] tx_payload;
        logic [1:0]        filt_ctrl;
        logic [10:0]       rej_id;
        logic [10:0]       acc_val;
        logic [10:0]       acc_mask;
        logic              sends_sync;
        logic [10:0]       own_id;
        logic [2:0]        irq_status;
        logic [2:0]        irq_mask;
        poc_state_t        prev_state;
        logic [15:0]       rdata;
        ident_write_t      tab;
    } block_state_t;
endpackage

// [design/sync_count_and_buffer_regs.sv]
// Sync frame counters, receive FIFO depth, buffer control words and the
// transmit window registers, reached over a plain 16-bit register port.
// Assumes the protocol engine runs on i_clk and drives i_engine directly.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
`include "sync_count_regs.svh"
module sync_count_and_buffer_regs
(
    input  wire logic                          i_clk,
    input  wire logic                          i_rst,
    input  wire sync_count_pkg::reg_req_t      i_req,
    output logic [15:0]                        o_rdata,
    output logic                               o_irq,
    input  wire sync_count_pkg::engine_in_t    i_engine,
    output sync_count_pkg::ident_write_t       o_table,
    output logic [5:0]                         o_fifo_buffers,
    output logic [58:0]                        o_buffer_valid,
    output logic [58:0]                        o_buffer_irq
);
    import sync_count_pkg::*;

    block_state_t st;
    block_state_t next_st;

    // ==========================================================
    // Decoding helpers

    // Buffer count for a FIFO depth code.
    function automatic logic [5:0] fifo_count(input logic [5:0] code);
        if (code <= `FIFO_CODE_MAX)
        begin
            return code;
        end
        return `FIFO_ALL_BUFFERS;
    endfunction

    // True when the address hits a buffer control word.
    function automatic logic is_buf(input logic [9:0] a);
        return (a >= `OFS_BUFFER0) && (a <= `OFS_BUFFER58) && (a[1:0] == 2'b00);
    endfunction

    // Buffer index of a buffer control word address.
    function automatic logic [5:0] buf_idx(input logic [9:0] a);
        logic [9:0] d;
        d = a - `OFS_BUFFER0;
        return d[7:2];
    endfunction

    // True when the address hits a transmit payload word.
    function automatic logic is_pay(input logic [9:0] a);
        return (a >= `OFS_TX_PAYLOAD0) && (a <= `OFS_TX_PAYLOAD15) && (a[0] == 1'b0);
    endfunction

    // Payload word index of a payload address.
    function automatic logic [3:0] pay_idx(input logic [9:0] a);
        logic [9:0] d;
        d = a - `OFS_TX_PAYLOAD0;
        return d[4:1];
    endfunction

    // ==========================================================
    // Engine-side conditions
    logic       normal;
    logic       enter_clear;
    logic       clr_even;
    logic       clr_odd;
    logic       filt_pass;
    logic       accept;
    logic [3:0] clr_value;
    logic [2:0] ev;

    // Sync frame filtering and the clear conditions.
    always_comb
    begin
        normal = (i_engine.state == POC_NORMAL_ACTIVE) || (i_engine.state == POC_NORMAL_PASSIVE);
        enter_clear = (i_engine.state != st.prev_state) &&
                      ((i_engine.state == POC_INIT_SCHEDULE) ||
                       (i_engine.state == POC_COLDSTART_COLLISION));
        clr_even = enter_clear || (normal && i_engine.idle_odd);
        clr_odd  = enter_clear || (normal && i_engine.even_end);
        filt_pass = 1'b1;
        // Filtering is on when either filter is switched on; both may stack.
        if (st.filt_ctrl[0] && (i_engine.sync_id == st.rej_id))
        begin
            filt_pass = 1'b0;
        end
        if (st.filt_ctrl[1] && (((i_engine.sync_id ^ st.acc_val) & st.acc_mask) != 11'h000))
        begin
            filt_pass = 1'b0;
        end
        accept = i_engine.sync_valid && filt_pass;
        clr_value = st.sends_sync ? 4'h1 : 4'h0;
    end

    // ==========================================================
    // Next-state logic
    always_comb
    begin
        next_st = st;
        next_st.rdata = 16'h0000;
        next_st.tab.even_we = 1'b0;
        next_st.tab.odd_we = 1'b0;
        next_st.prev_state = i_engine.state;
        ev = 3'b000;

        // Host writes; the counters have no write path at all.
        if (i_req.write)
        begin
            unique case (i_req.addr)
                `OFS_FIFO_DEPTH:
                begin
                    if (i_engine.state == POC_CONFIG)
                    begin
                        next_st.fifo_code = i_req.wdata[5:0];
                    end
                    else
                    begin
                        ev[`IRQ_FIFO_REFUSED] = 1'b1;
                    end
                end
                `OFS_IRQ_STATUS:
                begin
                    next_st.irq_status = st.irq_status & ~i_req.wdata[2:0];
                end
                `OFS_IRQ_MASK:
                begin
                    next_st.irq_mask = i_req.wdata[2:0];
                end
                `OFS_FILTER_CTRL:
                begin
                    next_st.filt_ctrl = i_req.wdata[1:0];
                end
                `OFS_REJECT_FILTER:
                begin
                    next_st.rej_id = i_req.wdata[10:0];
                end
                `OFS_ACCEPT_VALUE:
                begin
                    next_st.acc_val = i_req.wdata[10:0];
                end
                `OFS_ACCEPT_MASK:
                begin
                    next_st.acc_mask = i_req.wdata[10:0];
                end
                `OFS_NODE_CONFIG:
                begin
                    next_st.sends_sync = i_req.wdata[`NODE_SENDS_SYNC_BIT];
                    next_st.own_id = i_req.wdata[10:0];
                end
                `OFS_TX_IDENT:
                begin
                    next_st.tx_ident = i_req.wdata;
                end
                `OFS_TX_CYCLE_LEN:
                begin
                    next_st.tx_len = i_req.wdata[6:0];
                end
                `OFS_TX_HDR_CHECK:
                begin
                    next_st.tx_hcrc = i_req.wdata[10:0];
                end
                default:
                begin
                    if (is_buf(i_req.addr))
                    begin
                        next_st.bufw[buf_idx(i_req.addr)] = i_req.wdata & `BUF_WRITE_MASK;
                    end
                    else if (is_pay(i_req.addr))
                    begin
                        next_st.tx_payload[pay_idx(i_req.addr)] = i_req.wdata;
                    end
                end
            endcase
        end

        // Even counter: a clear wins over a frame in the same cycle.
        if (clr_even)
        begin
            next_st.even_count = clr_value;
            next_st.tab.even_we = st.sends_sync;
            next_st.tab.even_idx = 4'h0;
            next_st.tab.even_id = st.own_id;
        end
        else if (accept && !i_engine.cycle_odd && (st.even_count != `COUNT_FULL))
        begin
            next_st.even_count = st.even_count + 4'h1;
            next_st.tab.even_we = 1'b1;
            next_st.tab.even_idx = st.even_count;
            next_st.tab.even_id = i_engine.sync_id;
            ev[`IRQ_EVEN_COUNTED] = 1'b1;
        end

        // Odd counter, same scheme on the odd table.
        if (clr_odd)
        begin
            next_st.odd_count = clr_value;
            next_st.tab.odd_we = st.sends_sync;
            next_st.tab.odd_idx = 4'h0;
            next_st.tab.odd_id = st.own_id;
        end
        else if (accept && i_engine.cycle_odd && (st.odd_count != `COUNT_FULL))
        begin
            next_st.odd_count = st.odd_count + 4'h1;
            next_st.tab.odd_we = 1'b1;
            next_st.tab.odd_idx = st.odd_count;
            next_st.tab.odd_id = i_engine.sync_id;
            ev[`IRQ_ODD_COUNTED] = 1'b1;
        end

        // Hardware sets come after the host clear so a set is never lost.
        next_st.irq_status = next_st.irq_status | ev;
        if (i_engine.buf_event && (i_engine.buf_event_idx <= `BUFFER_LAST))
        begin
            next_st.bufw[i_engine.buf_event_idx][`BUF_IRQ_FLAG_BIT] = 1'b1;
        end

        // Read data is taken from the current state and shown next cycle.
        if (i_req.read)
        begin
            unique case (i_req.addr)
                `OFS_FIFO_DEPTH:    next_st.rdata = {10'h000, st.fifo_code};
                `OFS_IRQ_STATUS:    next_st.rdata = {13'h0000, st.irq_status};
                `OFS_IRQ_MASK:      next_st.rdata = {13'h0000, st.irq_mask};
                `OFS_FILTER_CTRL:   next_st.rdata = {14'h0000, st.filt_ctrl};
                `OFS_REJECT_FILTER: next_st.rdata = {5'h00, st.rej_id};
                `OFS_ACCEPT_VALUE:  next_st.rdata = {5'h00, st.acc_val};
                `OFS_ACCEPT_MASK:   next_st.rdata = {5'h00, st.acc_mask};
                `OFS_NODE_CONFIG:   next_st.rdata = {st.sends_sync, 4'h0, st.own_id};
                `OFS_TX_IDENT:      next_st.rdata = st.tx_ident;
                `OFS_TX_CYCLE_LEN:  next_st.rdata = {9'h000, st.tx_len};
                `OFS_TX_HDR_CHECK:  next_st.rdata = {5'h00, st.tx_hcrc};
                `OFS_EVEN_COUNT:    next_st.rdata = {12'h000, st.even_count};
                `OFS_ODD_COUNT:     next_st.rdata = {12'h000, st.odd_count};
                default:
                begin
                    if (is_buf(i_req.addr))
                    begin
                        next_st.rdata = st.bufw[buf_idx(i_req.addr)];
                    end
                    else if (is_pay(i_req.addr))
                    begin
                        next_st.rdata = st.tx_payload[pay_idx(i_req.addr)];
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // State register. Clearing every bit but prev_state, which loads POC_CONFIG,
    // is a legal choice for the undefined ones and keeps simulation free of unknowns.
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            st <= '0;
            st.prev_state <= POC_CONFIG;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs.
    assign o_rdata = st.rdata;
    assign o_irq = |(st.irq_status & st.irq_mask);
    assign o_table = st.tab;
    assign o_fifo_buffers = fifo_count(st.fifo_code);

    // Per-buffer valid and pending interrupt lines.
    genvar gi;
    generate
        for (gi = 0; gi < `BUFFER_COUNT; gi = gi + 1)
        begin : g_buf
            assign o_buffer_valid[gi] = st.bufw[gi][15];
            assign o_buffer_irq[gi] = st.bufw[gi][3] & st.bufw[gi][`BUF_IRQ_FLAG_BIT];
        end
    endgenerate
endmodule

// [verification/sync_count_chk.sv]
// Concurrent checks on the ports of the sync count register block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ns
module sync_count_chk
(
    input wire logic                       i_clk,
    input wire logic                       i_rst,
    input wire sync_count_pkg::reg_req_t   i_req,
    input wire logic [15:0]                o_rdata,
    input wire logic                       o_irq,
    input wire sync_count_pkg::engine_in_t i_engine,
    input wire sync_count_pkg::ident_write_t o_table,
    input wire logic [5:0]                 o_fifo_buffers,
    input wire logic [58:0]                o_buffer_valid,
    input wire logic [58:0]                o_buffer_irq
);
    import sync_count_pkg::*;
    // ==========================================================
    // Read answers, the locked depth write and table writes, all on the one clock.
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_rdata_idle: assert property (!$past(i_req.read) |-> o_rdata == 16'h0000)
        else $error("read data not zero outside a read answer");
    a_count_upper: assert property ($past(i_req.read) && $past(i_req.addr) == 10'h33C |-> o_rdata[15:4] == 12'h000)
        else $error("counter upper bits not zero");
    a_fifo_decode: assert property ($past(i_req.read) && $past(i_req.addr) == 10'h018 |->
        o_rdata[15:6] == 10'h000 && o_fifo_buffers == (o_rdata[5:0] > 6'h3A ? 6'h3B : o_rdata[5:0]))
        else $error("fifo buffer count does not follow the code");
    a_fifo_locked: assert property (i_req.write && i_req.addr == 10'h018 && i_engine.state != POC_CONFIG
        |=> $stable(o_fifo_buffers)) else $error("fifo depth changed outside configuration");
    a_cycle_field: assert property ($past(i_req.read) && $past(i_req.addr) == 10'h182 |-> o_rdata[15:7] == 9'h000)
        else $error("cycle number field not zero");
    a_buffer_gap: assert property (i_req.read && i_req.addr >= 10'h200 && i_req.addr <= 10'h2EB
        && i_req.addr[1:0] != 2'b00 |=> o_rdata == 16'h0000) else $error("gap between buffer words not empty");
    a_even_entry: assert property (o_table.even_we && o_table.even_idx != 4'h0 |-> $past(i_engine.sync_valid)
        && !$past(i_engine.cycle_odd) && o_table.even_id == $past(i_engine.sync_id))
        else $error("even table write without an even frame");
    a_odd_entry: assert property (o_table.odd_we && o_table.odd_idx != 4'h0 |-> $past(i_engine.sync_valid)
        && $past(i_engine.cycle_odd) && o_table.odd_id == $past(i_engine.sync_id))
        else $error("odd table write without an odd frame");
    a_clear_cause: assert property (o_table.even_we && !$past(i_engine.sync_valid) |-> $past(i_engine.idle_odd)
        || $past(i_engine.state) != $past(i_engine.state, 2)) else $error("even entry zero written without a clear");
    // Main scenarios reached.
    c_even_frame: cover property (o_table.even_we && o_table.even_idx != 4'h0);
    c_fifo_refused: cover property (i_req.write && i_req.addr == 10'h018 && i_engine.state != POC_CONFIG);
    c_irq_high: cover property (o_irq);
endmodule
bind sync_count_and_buffer_regs sync_count_chk i_sync_count_chk (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req),
    .o_rdata(o_rdata), .o_irq(o_irq), .i_engine(i_engine), .o_table(o_table),
    .o_fifo_buffers(o_fifo_buffers), .o_buffer_valid(o_buffer_valid), .o_buffer_irq(o_buffer_irq));

// [verification/sync_engine_model.sv]
// Model of the protocol engine that feeds the block's engine inputs.
// Assumes the bench calls one task at a time, each starting on a rising edge.
`timescale 1ns/1ns
module sync_engine_model
(
    input  wire logic                  i_clk,
    output sync_count_pkg::engine_in_t o_engine
);
    import sync_count_pkg::*;
    // ==========================================================
    // Idle values; the identifier is scrambled while no frame is offered.
    initial
    begin
        o_engine = '0;
        o_engine.state = POC_CONFIG;
        o_engine.sync_id = 11'h7FF;
    end
    // Protocol state is a level held until changed.
    task automatic set_state(input poc_state_t s);
        @(posedge i_clk);
        o_engine.state <= s;
    endtask
    // One valid sync frame of the given parity, one cycle long.
    task automatic frame(input logic odd, input logic [10:0] id);
        @(posedge i_clk);
        o_engine.sync_valid <= 1'b1;
        o_engine.cycle_odd <= odd;
        o_engine.sync_id <= id;
        @(posedge i_clk);
        o_engine.sync_valid <= 1'b0;
        o_engine.sync_id <= ~id;
    endtask
    // Kind 0 is odd idle time, 1 end of even cycle, 2 a buffer event.
    task automatic pulse(input int kind, input logic [5:0] idx);
        @(posedge i_clk);
        o_engine.idle_odd <= (kind == 0);
        o_engine.even_end <= (kind == 1);
        o_engine.buf_event <= (kind == 2);
        o_engine.buf_event_idx <= idx;
        @(posedge i_clk);
        o_engine.idle_odd <= 1'b0;
        o_engine.even_end <= 1'b0;
        o_engine.buf_event <= 1'b0;
    endtask
endmodule

// [verification/sync_count_and_buffer_regs_bench.sv]
// Self-checking bench for the sync count register block.
// Assumes the engine model drives the engine side; the register port is driven here.
`timescale 1ns/1ns
`include "sync_count_regs.svh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_mismatch++; $display("Error %s expected %h seen %h", nm, ex, got); end end
module sync_count_and_buffer_regs_bench;
    import sync_count_pkg::*;
    logic         i_clk = 1'b0;
    logic         i_rst = 1'b1;
    reg_req_t     i_req = '0;
    logic [15:0]  o_rdata;
    logic         o_irq;
    engine_in_t   eng;
    ident_write_t o_table;
    logic [5:0]   fifo_b;
    logic [58:0]  buf_v;
    logic [58:0]  buf_i;
    int           n_mismatch = 0;
    int           num_checks = 0;
    logic [5:0]   codes [5] = '{6'h00, 6'h01, 6'h3A, 6'h3B, 6'h3F};
    // ==========================================================
    // Block and engine model.
    sync_count_and_buffer_regs i_sync_count_and_buffer_regs (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req),
        .o_rdata(o_rdata), .o_irq(o_irq), .i_engine(eng), .o_table(o_table), .o_fifo_buffers(fifo_b),
        .o_buffer_valid(buf_v), .o_buffer_irq(buf_i));
    sync_engine_model i_sync_engine_model (.i_clk(i_clk), .o_engine(eng));
    // ==========================================================
    // Register port cycles; each strobe is one cycle wide.
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_req.write <= 1'b1;
        i_req.addr <= a;
        i_req.wdata <= d;
        @(posedge i_clk);
        i_req.write <= 1'b0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic rdc(input logic [9:0] a, input logic [15:0] e, input string nm);
        @(posedge i_clk);
        i_req.read <= 1'b1;
        i_req.addr <= a;
        @(posedge i_clk);
        i_req.read <= 1'b0;
        #1;
        `CHK(nm, e, o_rdata)
    endtask
    // ==========================================================
    // Scenarios.
    task automatic t_reset;
        rdc(`OFS_FIFO_DEPTH, 16'h0000, "fifo depth");
        rdc(`OFS_BUFFER58, 16'h0000, "last buffer word");
        `CHK("irq", 1'b0, o_irq)
        $display("reset test done");
    endtask
    // Every code class, then the masked, gap and fixed fields.
    task automatic t_fifo;
        foreach (codes[k])
        begin
            wr(`OFS_FIFO_DEPTH, {10'h000, codes[k]});
            rdc(`OFS_FIFO_DEPTH, {10'h000, codes[k]}, "fifo code");
            `CHK("fifo buffers", (codes[k] > 6'h3A) ? 6'h3B : codes[k], fifo_b)
        end
        wr(10'h204, 16'hFFFF);
        rdc(10'h204, 16'hFF4D, "buffer word 1");
        `CHK("buffer valid", 1'b1, buf_v[1])
        wr(10'h202, 16'hFFFF);
        rdc(10'h202, 16'h0000, "buffer gap");
        wr(`OFS_TX_PAYLOAD15, 16'hBEEF);
        rdc(`OFS_TX_PAYLOAD15, 16'hBEEF, "payload 15");
        wr(`OFS_TX_CYCLE_LEN, 16'hFFFF);
        rdc(`OFS_TX_CYCLE_LEN, 16'h007F, "cycle and length");
        wr(`OFS_EVEN_COUNT, 16'hFFFF);
        rdc(`OFS_EVEN_COUNT, 16'h0000, "even count write");
        $display("fifo and window test done");
    endtask
    // Counting per parity, interrupt handling, cycle clears and saturation.
    task automatic t_count;
        i_sync_engine_model.set_state(POC_NORMAL_ACTIVE);
        for (int k = 0; k < 5; k++)
            i_sync_engine_model.frame(k > 2, 11'h010 + k[10:0]);
        rdc(`OFS_EVEN_COUNT, 16'h0003, "even count");
        rdc(`OFS_ODD_COUNT, 16'h0002, "odd count");
        rdc(`OFS_IRQ_STATUS, 16'h0003, "irq status");
        `CHK("masked irq", 1'b0, o_irq)
        wr(`OFS_IRQ_MASK, 16'h0001);
        `CHK("unmasked irq", 1'b1, o_irq)
        wr(`OFS_IRQ_STATUS, 16'h0001);
        `CHK("cleared irq", 1'b0, o_irq)
        i_sync_engine_model.pulse(0, 6'h00);
        rdc(`OFS_EVEN_COUNT, 16'h0000, "even after idle");
        rdc(`OFS_ODD_COUNT, 16'h0002, "odd after idle");
        i_sync_engine_model.pulse(1, 6'h00);
        rdc(`OFS_ODD_COUNT, 16'h0000, "odd after even end");
        repeat (16) i_sync_engine_model.frame(1'b0, 11'h020);
        rdc(`OFS_EVEN_COUNT, 16'h000F, "even saturated");
        $display("count test done");
    endtask
    // A sync node clears to one and its next frame lands in entry one.
    task automatic t_sync;
        wr(`OFS_NODE_CONFIG, 16'h8123);
        i_sync_engine_model.set_state(POC_INIT_SCHEDULE);
        rdc(`OFS_EVEN_COUNT, 16'h0001, "even after init");
        rdc(`OFS_ODD_COUNT, 16'h0001, "odd after init");
        i_sync_engine_model.frame(1'b0, 11'h055);
        #1;
        `CHK("table write", {1'b1, 4'h1, 11'h055}, {o_table.even_we, o_table.even_idx, o_table.even_id})
        i_sync_engine_model.set_state(POC_COLDSTART_COLLISION);
        rdc(`OFS_EVEN_COUNT, 16'h0001, "even after collision");
        $display("sync node test done");
    endtask
    // Reject filter, refused depth write, and a buffer event.
    task automatic t_filter;
        wr(`OFS_NODE_CONFIG, 16'h0000);
        wr(`OFS_IRQ_STATUS, 16'h0007);
        i_sync_engine_model.set_state(POC_NORMAL_PASSIVE);
        wr(`OFS_FILTER_CTRL, 16'h0001);
        wr(`OFS_REJECT_FILTER, 16'h0007);
        i_sync_engine_model.pulse(0, 6'h00);
        i_sync_engine_model.frame(1'b0, 11'h007);
        i_sync_engine_model.frame(1'b0, 11'h008);
        rdc(`OFS_EVEN_COUNT, 16'h0001, "filtered count");
        wr(`OFS_FIFO_DEPTH, 16'h0005);
        rdc(`OFS_FIFO_DEPTH, 16'h003F, "locked depth");
        rdc(`OFS_IRQ_STATUS, 16'h0005, "refused status");
        wr(10'h20C, 16'h0008);
        i_sync_engine_model.pulse(2, 6'h03);
        rdc(10'h20C, 16'h000C, "buffer flag");
        `CHK("buffer irq", 1'b1, buf_i[3])
        $display("filter test done");
    endtask
    // ==========================================================
    // Verdict, reached from the main sequence or the watchdog.
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Clock of 50 ns period.
    initial
    begin
        forever #25 i_clk = ~i_clk;
    end
    // Reset for 12 cycles, then the scenarios in turn.
    initial
    begin
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        t_reset;
        t_fifo;
        t_count;
        t_sync;
        t_filter;
        conclude;
    end
    // The tests need well under a thousand cycles; a hang ends here.
    initial
    begin
        repeat (5000) @(posedge i_clk);
        n_mismatch++;
        conclude;
    end
endmodule
